// ### core/mpw_ctrl.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "mpw_defines.svh"
module mpw_ctrl
  import mpw_pkg::*;
#(
  parameter bit MODULATION_SELECT = 1'b1,
  parameter int CW = 10,
  parameter logic [15:0] CAL_CYCLES = `MPW_CAL_CYCLES,
  parameter logic [15:0] IPD_CYCLES = `MPW_IPD_CYCLES,
  parameter logic [15:0] OPEN_CYCLES = `MPW_OPEN_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // host events, one-cycle pulses
  input wire logic ev_drive,
  input wire logic ev_stop,
  input wire logic ev_reset,
  // converter samples, 10-bit codes
  input wire logic [9:0] bus_voltage_channel,
  input wire logic [9:0] shunt_or_u_current_channel,
  input wire logic [9:0] w_current_channel,
  input wire logic three_shunt,
  // comparator pins and dac reference
  input wire logic overcurrent_comparator,
  input wire logic hw_overcurrent,
  output logic [9:0] dac_ref,
  // voltage commands from the vector path
  input mpw_phase_t phase_cmd,
  input wire logic [15:0] volt_cmd,
  // outputs to control path
  output logic signed [15:0] bus_mv,
  output logic signed [15:0] i_link_ma,
  output logic signed [15:0] i_w_ma,
  output logic [15:0] mod_factor,
  output mpw_cmd_t cmd_ref,
  output mpw_sys_t sys_state,
  output mpw_run_t run_state,
  // interrupt and register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // gates
  output logic [2:0] gate_hi,
  output logic [2:0] gate_lo
);
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_MASK = 4'h4;
  localparam logic [3:0] A_STATE = 4'h8;
  localparam logic [3:0] A_DAC = 4'hc;

  // pin sync: comparator and hardware trip come from the analog side
  logic [1:0] cmp_s;
  logic [1:0] hwoc_s;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cmp_s <= 2'b00;
      hwoc_s <= 2'b00;
    end else begin
      cmp_s <= {cmp_s[0], overcurrent_comparator};
      hwoc_s <= {hwoc_s[0], hw_overcurrent};
    end
  end
  wire cmp_hit = cmp_s[1];
  // the raw pin also cuts gates so the trip does not wait for sync
  wire hw_trip = hw_overcurrent | hwoc_s[1];
  // state logic and flags see only the synced copy; a raw async pin there could split states
  wire hw_sync = hwoc_s[1];

  // scaling: mV = code*111000/1023, mA = code*10000/1023 - 5000
  wire [31:0] bus_prod = 32'(bus_voltage_channel) * 32'd111000;
  wire [31:0] iu_prod = 32'(shunt_or_u_current_channel) * 32'd10000;
  wire [31:0] iw_prod = 32'(w_current_channel) * 32'd10000;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bus_mv <= '0;
      i_link_ma <= '0;
      i_w_ma <= '0;
    end else begin
      bus_mv <= 16'(bus_prod / 32'd1023);
      i_link_ma <= 16'(iu_prod / 32'd1023) - 16'sd5000;
      i_w_ma <= three_shunt ? 16'(iw_prod / 32'd1023) - 16'sd5000 : 16'sd0;
    end
  end

  // modulation factor in q15: volt_cmd (mV) / bus (mV)
  wire [31:0] mod_num = {1'b0, volt_cmd, 15'h0000};
  wire [15:0] bus_den = (bus_mv > 16'sd0) ? 16'(bus_mv) : 16'h0001;
  wire [31:0] mod_q = mod_num / 32'(bus_den);
  always_ff @(posedge clk_sys) begin
    if (!resetn) mod_factor <= '0;
    else mod_factor <= (mod_q > 32'(`MPW_FULL_SCALE)) ? `MPW_FULL_SCALE : mod_q[15:0];
  end

  // fault detection
  wire ov_err = bus_voltage_channel > `MPW_OV_LIMIT_CODE;
  wire uv_err = bus_voltage_channel < `MPW_UV_LIMIT_CODE;
  wire fault = ov_err | uv_err | hw_sync | (cmp_hit & (run_state != MPW_RUN_IPD));
  wire ev_error = fault & (sys_state == MPW_SYS_ACTIVE);

  // state machines
  logic [15:0] timer;
  mpw_sys_t next_sys;
  mpw_run_t next_run;
  wire tmo_cal = timer >= CAL_CYCLES;
  wire tmo_open = timer >= OPEN_CYCLES;
  wire ipd_end = cmp_hit | (timer >= IPD_CYCLES);

  always_comb begin
    next_sys = sys_state;
    next_run = run_state;
    unique case (sys_state)
      MPW_SYS_INACTIVE: begin
        if (ev_drive) begin
          next_sys = MPW_SYS_ACTIVE;
          next_run = MPW_RUN_OFFSET_CAL;
        end
      end
      MPW_SYS_ACTIVE: begin
        if (ev_error) begin
          next_sys = MPW_SYS_ERROR;
          next_run = MPW_RUN_END;
        end else if (ev_stop) begin
          next_sys = MPW_SYS_INACTIVE;
          next_run = MPW_RUN_END;
        end else begin
          unique case (run_state)
            MPW_RUN_OFFSET_CAL: if (tmo_cal) next_run = MPW_RUN_OFFSET_DONE;
            MPW_RUN_OFFSET_DONE: next_run = MPW_RUN_IPD;
            MPW_RUN_IPD: if (ipd_end) next_run = MPW_RUN_IPD_DONE;
            MPW_RUN_IPD_DONE: next_run = MPW_RUN_OPEN;
            MPW_RUN_OPEN: if (tmo_open) next_run = MPW_RUN_CLOSED;
            MPW_RUN_CLOSED: next_run = MPW_RUN_CLOSED;
            MPW_RUN_BRAKE: next_run = MPW_RUN_END;
            MPW_RUN_END: next_run = MPW_RUN_END;
          endcase
        end
      end
      MPW_SYS_ERROR: begin
        if (ev_reset) next_sys = MPW_SYS_INACTIVE;
      end
      default: next_sys = MPW_SYS_ERROR;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sys_state <= MPW_SYS_INACTIVE;
      run_state <= MPW_RUN_END;
      timer <= '0;
    end else begin
      sys_state <= next_sys;
      run_state <= next_run;
      timer <= (next_run != run_state) ? 16'h0000 : timer + 16'h0001;
    end
  end

  // command references follow the run state
  always_ff @(posedge clk_sys) begin
    if (!resetn) cmd_ref <= '0;
    else begin
      cmd_ref.id_ref <= 16'sd0;
      cmd_ref.iq_ref <= (run_state == MPW_RUN_OPEN) ? `MPW_OPEN_IQ : 16'sd0;
      cmd_ref.speed_ref <= (run_state == MPW_RUN_OPEN) ? `MPW_OPEN_SPEED :
                           (run_state == MPW_RUN_CLOSED) ? `MPW_RUN_SPEED : 16'sd0;
    end
  end

  // harmonic offset; min/max picked combinationally
  wire signed [15:0] mx_uv = (phase_cmd.u > phase_cmd.v) ? phase_cmd.u : phase_cmd.v;
  wire signed [15:0] mn_uv = (phase_cmd.u < phase_cmd.v) ? phase_cmd.u : phase_cmd.v;
  wire signed [15:0] vmax = (mx_uv > phase_cmd.w) ? mx_uv : phase_cmd.w;
  wire signed [15:0] vmin = (mn_uv < phase_cmd.w) ? mn_uv : phase_cmd.w;
  wire signed [16:0] vsum = 17'(vmax) + 17'(vmin);
  wire signed [15:0] v_off = MODULATION_SELECT ? 16'(vsum >>> 1) : 16'sd0;
  wire signed [15:0] mu = phase_cmd.u - v_off;
  wire signed [15:0] mv = phase_cmd.v - v_off;
  wire signed [15:0] mw = phase_cmd.w - v_off;
  // signed command taken to offset binary over the full CW-bit range, not clipped to the carrier peak; top bits used, trading resolution for width
  function automatic logic [CW-1:0] to_duty(input logic signed [15:0] c);
    logic [15:0] b;
    b = 16'(c) ^ 16'h8000;
    return b[15 -: CW];
  endfunction
  wire [3*CW-1:0] duty = {to_duty(mw), to_duty(mv), to_duty(mu)};

  // gates run only while active and no fault; hw trip gates outputs directly
  wire pwm_en = (sys_state == MPW_SYS_ACTIVE) & (run_state != MPW_RUN_OFFSET_CAL) &
                (run_state != MPW_RUN_END) & ~ov_err & ~uv_err;
  logic [2:0] core_hi;
  logic [2:0] core_lo;
  mpw_pwm_core #(.CW(CW)) u_core (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .duty(duty),
    .enable(pwm_en),
    .gate_hi(core_hi),
    .gate_lo(core_lo)
  );
  assign gate_hi = hw_trip ? 3'b000 : core_hi;
  assign gate_lo = hw_trip ? 3'b000 : core_lo;

  // status: 0 ov, 1 uv, 2 comparator, 3 hw trip, 4 run state change
  logic [4:0] status;
  logic [4:0] mask;
  logic [9:0] dac_q;
  wire [4:0] ev_bits = {next_run != run_state, hw_sync, cmp_hit, uv_err, ov_err};
  wire wr_status = reg_wr & (reg_addr == A_STATUS);
  wire [4:0] clr_bits = wr_status ? reg_wdata[4:0] : 5'h00;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      status <= '0;
      mask <= '0;
      dac_q <= 10'h3ff;
      reg_rdata <= '0;
    end else begin
      status <= (status & ~clr_bits) | ev_bits;
      if (reg_wr & (reg_addr == A_MASK)) mask <= reg_wdata[4:0];
      if (reg_wr & (reg_addr == A_DAC)) dac_q <= reg_wdata[9:0];
      if (reg_rd) begin
        unique case (reg_addr)
          A_STATUS: reg_rdata <= {27'h0, status};
          A_MASK: reg_rdata <= {27'h0, mask};
          A_STATE: reg_rdata <= {27'h0, run_state, sys_state};
          A_DAC: reg_rdata <= {22'h0, dac_q};
          default: reg_rdata <= 32'h0;
        endcase
      end else reg_rdata <= 32'h0;
    end
  end
  assign dac_ref = dac_q;
  assign irq = |(status & mask);

  a_trip_cut: assert property (@(posedge clk_sys) disable iff (!resetn)
    hw_overcurrent |-> (gate_hi == 3'b000 && gate_lo == 3'b000)) else $error("gates on in trip");
  a_no_spont_start: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sys_state == MPW_SYS_INACTIVE && !ev_drive) |=> sys_state == MPW_SYS_INACTIVE)
    else $error("drive began without event");
  a_fault_stop: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sys_state == MPW_SYS_ACTIVE && ev_error) |=> sys_state == MPW_SYS_ERROR ##1 !pwm_en)
    else $error("fault did not stop drive");
  a_run_order: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run_state == MPW_RUN_OFFSET_DONE && sys_state == MPW_SYS_ACTIVE && !ev_stop && !ev_error)
    |=> run_state == MPW_RUN_IPD) else $error("sub-state out of order");
  a_state_legal: assert property (@(posedge clk_sys) disable iff (!resetn)
    sys_state != 2'b11) else $error("illegal system state");
  a_err_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sys_state == MPW_SYS_ERROR && !ev_reset) |=> sys_state == MPW_SYS_ERROR)
    else $error("error left without reset");
  a_run_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run_state == MPW_RUN_CLOSED && !ev_stop && !ev_error) |=> $stable(run_state))
    else $error("run state moved");
  a_cmd_open: assert property (@(posedge clk_sys) disable iff (!resetn)
    run_state == MPW_RUN_OPEN |=> cmd_ref.iq_ref == `MPW_OPEN_IQ) else $error("open iq");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn)
    irq == |(status & mask)) else $error("irq mismatch");
  c_start: cover property (@(posedge clk_sys) disable iff (!resetn)
    sys_state == MPW_SYS_INACTIVE ##1 sys_state == MPW_SYS_ACTIVE);
  c_closed: cover property (@(posedge clk_sys) disable iff (!resetn)
    run_state == MPW_RUN_CLOSED);
  c_error: cover property (@(posedge clk_sys) disable iff (!resetn)
    sys_state == MPW_SYS_ERROR ##[1:20] sys_state == MPW_SYS_INACTIVE);
  c_ipd_hit: cover property (@(posedge clk_sys) disable iff (!resetn)
    run_state == MPW_RUN_IPD && cmp_hit);
  c_irq: cover property (@(posedge clk_sys) disable iff (!resetn)
    $rose(irq));

  // flags: an event in the cycle of a clear must still leave its bit set
  a_set_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
    ev_bits[0] |=> status[0]) else $error("ov flag lost");
  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
    (status[3] && !clr_bits[3]) |=> status[3]) else $error("trip flag dropped");
  // gates are registered, so a voltage fault shows at the pins one cycle later
  a_ov_halt: assert property (@(posedge clk_sys) disable iff (!resetn)
    ov_err |=> (gate_hi == 3'b000 && gate_lo == 3'b000))
    else $error("gates on in overvoltage");
  a_stop_end: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sys_state == MPW_SYS_ACTIVE && ev_stop && !ev_error)
    |=> (sys_state == MPW_SYS_INACTIVE && run_state == MPW_RUN_END))
    else $error("stop did not end drive");
  a_mod_sat: assert property (@(posedge clk_sys) disable iff (!resetn)
    mod_factor <= `MPW_FULL_SCALE) else $error("modulation factor above full scale");
endmodule

// ### core/mpw_defines.svh
`ifndef MPW_DEFINES_SVH
`define MPW_DEFINES_SVH
`define MPW_CODE_FULL 10'h3ff
`define MPW_BUS_FULL_V 111
`define MPW_CUR_FULL_A 5
`define MPW_OV_LIMIT_CODE 10'h0fc
`define MPW_UV_LIMIT_CODE 10'h06c
`define MPW_CAL_CYCLES 16'h0100
`define MPW_IPD_CYCLES 16'h0200
`define MPW_OPEN_CYCLES 16'h0400
`define MPW_CAR_PEAK 10'h3e7
`define MPW_FULL_SCALE 16'h7fff
`define MPW_OPEN_IQ 16'h0800
`define MPW_OPEN_SPEED 16'h0400
`define MPW_RUN_SPEED 16'h1000
`endif

// ### core/mpw_pkg.sv
package mpw_pkg;
  typedef enum logic [1:0] {
    MPW_SYS_INACTIVE = 2'b00,
    MPW_SYS_ACTIVE = 2'b01,
    MPW_SYS_ERROR = 2'b10
  } mpw_sys_t;
  typedef enum logic [2:0] {
    MPW_RUN_OFFSET_CAL = 3'b000,
    MPW_RUN_OFFSET_DONE = 3'b001,
    MPW_RUN_IPD = 3'b010,
    MPW_RUN_IPD_DONE = 3'b011,
    MPW_RUN_OPEN = 3'b100,
    MPW_RUN_CLOSED = 3'b101,
    MPW_RUN_BRAKE = 3'b110,
    MPW_RUN_END = 3'b111
  } mpw_run_t;
  typedef struct packed {
    logic signed [15:0] u;
    logic signed [15:0] v;
    logic signed [15:0] w;
  } mpw_phase_t;
  typedef struct packed {
    logic signed [15:0] id_ref;
    logic signed [15:0] iq_ref;
    logic signed [15:0] speed_ref;
  } mpw_cmd_t;
endpackage

// ### core/mpw_pwm_core.sv
`timescale 1ns/1ns
`include "mpw_defines.svh"
module mpw_pwm_core
  import mpw_pkg::*;
#(
  parameter int CW = 10,
  parameter logic [9:0] PEAK = `MPW_CAR_PEAK
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // duty values, offset binary over the full CW-bit range
  input wire logic [3*CW-1:0] duty,
  input wire logic enable,
  // gate outputs
  output logic [2:0] gate_hi,
  output logic [2:0] gate_lo
);
  logic [CW-1:0] carrier;
  logic dir_up;
  logic [3*CW-1:0] held;
  wire at_bottom = (carrier == '0);
  wire at_top = (carrier == PEAK);
  wire extremum = at_bottom | at_top;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      carrier <= '0;
      dir_up <= 1'b1;
      held <= '0;
    end else begin
      if (dir_up) carrier <= at_top ? carrier - 1'b1 : carrier + 1'b1;
      else carrier <= at_bottom ? carrier + 1'b1 : carrier - 1'b1;
      if (at_top) dir_up <= 1'b0;
      else if (at_bottom) dir_up <= 1'b1;
      if (extremum) held <= duty;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ph
      wire on_state = held[i*CW +: CW] > carrier;
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          gate_hi[i] <= 1'b0;
          gate_lo[i] <= 1'b0;
        end else begin
          gate_hi[i] <= enable & on_state;
          gate_lo[i] <= enable & ~on_state;
        end
      end
    end
  endgenerate

  a_carrier_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
    carrier <= PEAK) else $error("carrier above peak");
  a_hold_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
    !$past(extremum) |-> held == $past(held)) else $error("duty changed mid ramp");
endmodule

// ### test/mpw_inverter_model.sv
`timescale 1ns/1ns
module mpw_inverter_model (
  // bench settings
  input wire logic [9:0] bus_code,
  input wire logic [9:0] i_code,
  input wire logic hw_trip,
  // bridge and sensing side
  input wire logic [2:0] gate_hi,
  input wire logic [9:0] dac_ref,
  output logic [9:0] bus_voltage_channel,
  output logic [9:0] shunt_or_u_current_channel,
  output logic [9:0] w_current_channel,
  output logic overcurrent_comparator,
  output logic hw_overcurrent
);
  assign bus_voltage_channel = bus_code;
  // u current steps up while its high switch conducts, so a stuck gate shows
  assign shunt_or_u_current_channel = gate_hi[0] ? i_code + 10'h010 : i_code;
  // w mirrors u about mid scale; no saturation modelled near the ends
  assign w_current_channel = 10'h3ff - shunt_or_u_current_channel;
  assign overcurrent_comparator = shunt_or_u_current_channel > dac_ref;
  assign hw_overcurrent = hw_trip;
endmodule

// ### test/tb_mpw_ctrl.sv
`timescale 1ns/1ns
module tb_mpw_ctrl;
  import mpw_pkg::*;
  localparam logic [15:0] CAL = 16'h0008;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] evs = 3'h0;
  logic [9:0] bus_code = 10'h0a0;
  logic [9:0] i_code = 10'h200;
  logic hw_trip = 1'b0;
  logic three_shunt = 1'b0;
  mpw_phase_t phase_cmd = '0;
  logic [15:0] volt_cmd = 16'h0000;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [9:0] bus_ch, u_ch, w_ch, dac_ref;
  logic cmp, hw_oc, irq, rd_q;
  logic signed [15:0] bus_mv, i_link_ma, i_w_ma;
  logic [15:0] mod_factor;
  mpw_cmd_t cmd_ref;
  mpw_sys_t sys_state;
  mpw_run_t run_state;
  logic [31:0] reg_rdata, lf;
  logic [2:0] gate_hi, gate_lo;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int checks = 0;
  int n;
  mpw_ctrl #(.CAL_CYCLES(CAL), .IPD_CYCLES(16'h0010), .OPEN_CYCLES(16'h0008)) u_mpw_ctrl (
    .clk_sys(clk_sys), .resetn(resetn), .ev_drive(evs[0]), .ev_stop(evs[1]),
    .ev_reset(evs[2]), .bus_voltage_channel(bus_ch), .shunt_or_u_current_channel(u_ch),
    .w_current_channel(w_ch), .three_shunt(three_shunt), .overcurrent_comparator(cmp),
    .hw_overcurrent(hw_oc), .dac_ref(dac_ref), .phase_cmd(phase_cmd), .volt_cmd(volt_cmd),
    .bus_mv(bus_mv), .i_link_ma(i_link_ma), .i_w_ma(i_w_ma), .mod_factor(mod_factor),
    .cmd_ref(cmd_ref), .sys_state(sys_state), .run_state(run_state), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .gate_hi(gate_hi), .gate_lo(gate_lo));
  mpw_inverter_model u_mpw_inverter_model (
    .bus_code(bus_code), .i_code(i_code), .hw_trip(hw_trip), .gate_hi(gate_hi),
    .dac_ref(dac_ref), .bus_voltage_channel(bus_ch), .shunt_or_u_current_channel(u_ch),
    .w_current_channel(w_ch), .overcurrent_comparator(cmp), .hw_overcurrent(hw_oc));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input logic signed [31:0] got, input int exp, input int tol);
    checks++;
    if ((^got === 1'bx) || (got - exp > tol) || (exp - got > tol)) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read data stand only in the cycle after the strobe, so pop on that edge
  always @(posedge clk_sys) begin
    if (rd_q === 1'b1 && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
    rd_q <= reg_rd;
  end
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic ev(input logic [2:0] e);
    @(posedge clk_sys);
    evs <= e;
    @(posedge clk_sys);
    evs <= 3'h0;
    #1;
  endtask
  task automatic wait_st(input logic [4:0] e, input int lim);
    n = 0;
    while ({run_state, sys_state} !== e && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk({run_state, sys_state}, e);
  endtask
  task automatic end_sim;
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    lf = 32'd68460;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({gate_hi, gate_lo, irq, run_state, sys_state}, 32'h1c);
    rd(4'h8, 32'h1c);
    rd(4'hc, 32'h3ff);
    rd(4'h3, 32'h0);
    wr(4'hc, 32'h155);
    rd(4'hc, 32'h155);
    wr(4'hc, 32'h3ff);
    three_shunt <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      bus_code <= (k == 0) ? 10'h000 : 10'h0a0;
      i_code <= (k == 0) ? 10'h000 : ((k == 1) ? 10'h3ff : 10'h200);
      volt_cmd <= 16'd8680;
      repeat (4) @(posedge clk_sys);
      #1;
      chk_near(bus_mv, int'(bus_code) * 111000 / 1023, 8);
      chk_near(i_link_ma, int'(i_code) * 10000 / 1023 - 5000, 8);
      chk_near(i_w_ma, 5000 - int'(i_code) * 10000 / 1023, 8);
    end
    chk_near($signed({16'h0, mod_factor}), 16384, 8);
    ev(3'b010);
    ev(3'b100);
    chk({run_state, sys_state}, 5'h1c);
    lf = lfsr(lf);
    phase_cmd <= {lf[15:0], lf[31:16], lf[23:8]};
    ev(3'b001);
    chk({run_state, sys_state}, 5'h01);
    repeat (CAL - 1) @(posedge clk_sys);
    #1;
    chk({run_state, sys_state}, 5'h01);
    wait_st(5'h05, 4);
    wait_st(5'h09, 4);
    wait_st(5'h0d, 40);
    wait_st(5'h11, 4);
    wait_st(5'h15, 20);
    // equal commands leave zero after injection, so duty sits at mid scale
    phase_cmd <= {3{16'sh4000}};
    repeat (2100) @(posedge clk_sys);
    n = 0;
    repeat (1998) begin
      @(posedge clk_sys);
      #1;
      n += int'(gate_hi[0]);
    end
    chk_near(n, 1023, 8);
    chk({run_state, sys_state}, 5'h15);
    @(posedge clk_sys);
    hw_trip <= 1'b1;
    #1;
    chk({gate_hi, gate_lo}, 6'h00);
    wait_st(5'h1e, 8);
    chk(irq, 1'b0);
    wr(4'h4, 32'h08);
    chk(irq, 1'b1);
    @(posedge clk_sys);
    hw_trip <= 1'b0;
    // let the synced trip copy drain, else set wins over the clear
    repeat (3) @(posedge clk_sys);
    wr(4'h0, 32'h08);
    chk(irq, 1'b0);
    rd(4'h8, 32'h1e);
    ev(3'b001);
    chk({run_state, sys_state}, 5'h1e);
    ev(3'b100);
    chk({run_state, sys_state}, 5'h1c);
    ev(3'b001);
    wait_st(5'h09, 20);
    ev(3'b010);
    @(posedge clk_sys);
    #1;
    chk({gate_hi, gate_lo, run_state, sys_state}, 32'h1c);
    ev(3'b001);
    @(posedge clk_sys);
    bus_code <= 10'h1ff;
    wait_st(5'h1e, 16);
    @(posedge clk_sys);
    #1;
    chk({gate_hi, gate_lo}, 6'h00);
    end_sim;
  end
endmodule
